// ### pkg/cfs_pkg.sv
// cfs_pkg: shared constants and types of the can fifo status block
package cfs_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the wishbone slave
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FIFO_STATUS = 8'h00; // fifo_pointer_status
    localparam logic [7:0] OFS_FLAGS = 8'h04; // interrupt_flags_and_error_state
    localparam logic [7:0] OFS_ENABLES = 8'h08; // interrupt_enables
    localparam logic [7:0] OFS_INTERRUPT_SOURCE_CODE = 8'h0C; // interrupt source code, ro
    localparam logic [7:0] OFS_FIFO_CTRL = 8'h10; // fifo area start, rw

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int WPTR_LSB = 8; // fifo_write_pointer at 13:8
    localparam int RPTR_LSB = 0; // fifo_next_read_pointer at 5:0
    localparam int TX_BUS_OFF_BIT = 13;
    localparam int TX_PASSIVE_BIT = 12;
    localparam int RX_PASSIVE_BIT = 11;
    localparam int TX_WARN_BIT = 10;
    localparam int RX_WARN_BIT = 9;
    localparam int ANY_WARN_BIT = 8;
    localparam int INVALID_BIT = 7;
    localparam int WAKEUP_BIT = 6;
    localparam int ERROR_BIT = 5;
    localparam int FIFO_AF_BIT = 3;
    localparam int RX_OVF_BIT = 2;
    localparam int RX_BUF_BIT = 1;
    localparam int TX_BUF_BIT = 0;

    // implemented flag and enable positions (bit 4 is absent)
    localparam logic [7:0] FLAG_MASK = 8'hEF;

    // ------------------------------------------------------------
    // reset values and pointer limits
    // ------------------------------------------------------------
    localparam logic [5:0] PTR_RESET = 6'h00;
    localparam logic [5:0] PTR_LAST = 6'h1F; // receive_buffer_last
    localparam logic [4:0] AREA_START_RESET = 5'h00; // txrx_buffer_zero
    localparam logic [7:0] ENABLE_RESET = 8'h00;

    // ------------------------------------------------------------
    // interrupt source codes
    // ------------------------------------------------------------
    localparam logic [6:0] CODE_FIFO_AF = 7'h44;
    localparam logic [6:0] CODE_RX_OVF = 7'h43;
    localparam logic [6:0] CODE_WAKEUP = 7'h42;
    localparam logic [6:0] CODE_ERROR = 7'h41;
    localparam logic [6:0] CODE_NONE = 7'h40;
    localparam logic [6:0] CODE_TX_BUF = 7'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } cfs_wb_req_type;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } cfs_wb_rsp_type;

    typedef struct packed {
        logic tx_bus_off;
        logic tx_passive;
        logic rx_passive;
        logic tx_warn;
        logic rx_warn;
    } cfs_err_state_type;

    typedef struct packed {
        logic invalid_msg;
        logic wakeup;
        logic fifo_almost_full;
        logic rx_overflow;
        logic rx_buffer;
        logic tx_buffer;
    } cfs_events_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] enable;
        logic [4:0] area_start;
        cfs_err_state_type err;
    } cfs_top_state_type;

    typedef struct packed {
        logic [5:0] ptr;
    } cfs_ptr_state_type;

    typedef struct packed {
        logic flag;
    } cfs_flag_state_type;

endpackage

// ### hw/cfs_flag_bit.sv
// cfs_flag_bit: one sticky interrupt request flag
`timescale 1ns/10ps
module cfs_flag_bit (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic set_i,
    input wire logic clear_i,
    output logic flag_o
);

    cfs_pkg::cfs_flag_state_type state_q; // registered state
    cfs_pkg::cfs_flag_state_type state_d; // next state

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // set beats clear so an event in the clearing cycle is kept
    always_comb begin
        state_d = state_q;
        state_d.flag = set_i | (state_q.flag & ~clear_i);
    end

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign flag_o = state_q.flag;

endmodule // cfs_flag_bit

// ### hw/cfs_area_ptr.sv
// cfs_area_ptr: buffer pointer walking the fifo area up to buffer 31
`timescale 1ns/10ps
module cfs_area_ptr (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic step_i,
    input wire logic [4:0] start_i,
    output logic [5:0] ptr_o
);

    cfs_pkg::cfs_ptr_state_type state_q; // registered state
    cfs_pkg::cfs_ptr_state_type state_d; // next state
    logic [5:0] start_ext; // area start widened to pointer width

    assign start_ext = {1'b0, start_i};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // a pointer left below a moved start is pulled up to the start,
    // so it names a buffer outside the area for one cycle at most
    always_comb begin
        state_d = state_q;
        if (state_q.ptr < start_ext) begin
            state_d.ptr = start_ext;
        end else if (step_i) begin
            if (state_q.ptr >= cfs_pkg::PTR_LAST) begin
                state_d.ptr = start_ext; // wrap to area start
            end else begin
                state_d.ptr = state_q.ptr + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q.ptr <= cfs_pkg::PTR_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign ptr_o = state_q.ptr;

endmodule // cfs_area_ptr

// ### hw/cfs_top.sv
// cfs_top: fifo status, error state and interrupt flags of a can node
//
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/10ps

module cfs_top (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input cfs_pkg::cfs_wb_req_type wb_req_i,
    output cfs_pkg::cfs_wb_rsp_type wb_rsp_o,
    input cfs_pkg::cfs_err_state_type err_state_i,
    input cfs_pkg::cfs_events_type events_i,
    input wire logic fifo_store_i,
    input wire logic fifo_read_done_i,
    output logic [6:0] interrupt_source_code_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    cfs_pkg::cfs_top_state_type state_q; // registered state
    cfs_pkg::cfs_top_state_type state_d; // next state
    logic [5:0] fifo_write_pointer; // buffer being filled
    logic [5:0] fifo_next_read_pointer; // buffer software reads next
    logic [7:0] flags; // latched request flags
    logic [7:0] flag_set; // event per flag position
    logic [7:0] flag_clear; // software clear per flag position
    logic [7:0] pending; // flags gated by enables
    logic [5:0] err_now; // error word bits 13:8 from inputs
    logic [5:0] err_old; // error word bits 13:8 as held
    logic err_rise; // some error condition newly entered
    logic any_warning_state; // combined warning of held state
    logic req; // new bus request not yet answered
    logic wr_lo; // write with byte lane 0 enabled
    logic [15:0] status_word; // fifo status register image
    logic [15:0] flag_word; // flag register image
    logic [15:0] read_word; // selected read value
    logic [6:0] code; // current interrupt source code

    // ------------------------------------------------------------
    // bus request decode
    // ------------------------------------------------------------
    // classic single cycle: answer once, then drop ack for a cycle
    assign req = wb_req_i.cyc & wb_req_i.stb & ~state_q.ack;
    // a write lands at the edge where the master sees ack, while its
    // request still stands; the ack mask makes it land only once
    assign wr_lo = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we
                   & wb_req_i.sel[0] & state_q.ack;

    // ------------------------------------------------------------
    // error state bits
    // ------------------------------------------------------------
    // the word bits are the held copy; a rise is taken against it
    assign err_now = {err_state_i.tx_bus_off,
                      err_state_i.tx_passive,
                      err_state_i.rx_passive,
                      err_state_i.tx_warn,
                      err_state_i.rx_warn,
                      err_state_i.tx_warn | err_state_i.rx_warn};
    assign any_warning_state = state_q.err.tx_warn
                               | state_q.err.rx_warn;
    assign err_old = {state_q.err.tx_bus_off,
                      state_q.err.tx_passive,
                      state_q.err.rx_passive,
                      state_q.err.tx_warn,
                      state_q.err.rx_warn,
                      any_warning_state};
    assign err_rise = |(err_now & ~err_old);

    // ------------------------------------------------------------
    // flag events
    // ------------------------------------------------------------
    always_comb begin
        flag_set = 8'h00;
        flag_set[cfs_pkg::INVALID_BIT] = events_i.invalid_msg;
        flag_set[cfs_pkg::WAKEUP_BIT] = events_i.wakeup;
        flag_set[cfs_pkg::ERROR_BIT] = err_rise;
        flag_set[cfs_pkg::FIFO_AF_BIT] =
            events_i.fifo_almost_full;
        flag_set[cfs_pkg::RX_OVF_BIT] = events_i.rx_overflow;
        flag_set[cfs_pkg::RX_BUF_BIT] = events_i.rx_buffer;
        flag_set[cfs_pkg::TX_BUF_BIT] = events_i.tx_buffer;
    end

    // writing zero clears; only the low lane carries flags
    assign flag_clear = (wr_lo && wb_req_i.adr == cfs_pkg::OFS_FLAGS)
                        ? ~wb_req_i.dat[7:0] : 8'h00;

    // ------------------------------------------------------------
    // flag bits, one instance per implemented position
    // ------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_flag
        if (cfs_pkg::FLAG_MASK[i]) begin : g_impl
            cfs_flag_bit u_flag (
                .ref_clk_i(ref_clk_i),
                .reset_i(reset_i),
                .set_i(flag_set[i]),
                .clear_i(flag_clear[i]),
                .flag_o(flags[i])
            );
        end else begin : g_none
            assign flags[i] = 1'b0; // absent position
        end
    end

    // ------------------------------------------------------------
    // fifo pointers
    // ------------------------------------------------------------
    // write pointer steps when the engine stores a message
    cfs_area_ptr u_write_ptr (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .step_i(fifo_store_i),
        .start_i(state_q.area_start),
        .ptr_o(fifo_write_pointer)
    );

    // read pointer steps when the buffer handling frees a buffer
    cfs_area_ptr u_read_ptr (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .step_i(fifo_read_done_i),
        .start_i(state_q.area_start),
        .ptr_o(fifo_next_read_pointer)
    );

    // ------------------------------------------------------------
    // register images
    // ------------------------------------------------------------
    always_comb begin
        status_word = 16'h0000; // unused bits stay zero
        status_word[cfs_pkg::WPTR_LSB +: 6] =
            fifo_write_pointer;
        status_word[cfs_pkg::RPTR_LSB +: 6] =
            fifo_next_read_pointer;
    end

    always_comb begin
        flag_word = 16'h0000; // bits 15:14 and 4 stay zero
        flag_word[7:0] = flags;
        flag_word[cfs_pkg::TX_BUS_OFF_BIT] =
            state_q.err.tx_bus_off;
        flag_word[cfs_pkg::TX_PASSIVE_BIT] =
            state_q.err.tx_passive;
        flag_word[cfs_pkg::RX_PASSIVE_BIT] =
            state_q.err.rx_passive;
        flag_word[cfs_pkg::TX_WARN_BIT] = state_q.err.tx_warn;
        flag_word[cfs_pkg::RX_WARN_BIT] = state_q.err.rx_warn;
        flag_word[cfs_pkg::ANY_WARN_BIT] = any_warning_state;
    end

    // ------------------------------------------------------------
    // interrupt source code
    // ------------------------------------------------------------
    // only enabled flags compete; the error class wins over buffers
    // because a failing bus starves the buffers anyway
    assign pending = flags & state_q.enable;

    always_comb begin
        if (pending[cfs_pkg::ERROR_BIT]) begin
            code = cfs_pkg::CODE_ERROR;
        end else if (pending[cfs_pkg::RX_OVF_BIT]) begin
            code = cfs_pkg::CODE_RX_OVF;
        end else if (pending[cfs_pkg::FIFO_AF_BIT]) begin
            code = cfs_pkg::CODE_FIFO_AF;
        end else if (pending[cfs_pkg::WAKEUP_BIT]) begin
            code = cfs_pkg::CODE_WAKEUP;
        end else if (pending[cfs_pkg::RX_BUF_BIT]) begin
            code = {1'b0, fifo_next_read_pointer}; // buffer number
        end else if (pending[cfs_pkg::TX_BUF_BIT]) begin
            code = cfs_pkg::CODE_TX_BUF;
        end else begin
            code = cfs_pkg::CODE_NONE;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    // unmapped addresses answer with zero
    always_comb begin
        case (wb_req_i.adr)
            cfs_pkg::OFS_FIFO_STATUS: begin
                read_word = status_word;
            end
            cfs_pkg::OFS_FLAGS: begin
                read_word = flag_word;
            end
            cfs_pkg::OFS_ENABLES: begin
                read_word = {8'h00, state_q.enable};
            end
            cfs_pkg::OFS_INTERRUPT_SOURCE_CODE: begin
                read_word = {9'h000, code};
            end
            cfs_pkg::OFS_FIFO_CTRL: begin
                read_word = {11'h000, state_q.area_start};
            end
            default: begin
                read_word = 16'h0000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.err = err_state_i; // held copy of the engine's state
        state_d.ack = req;
        if (req) begin
            state_d.rdata = {16'h0000, read_word};
        end
        if (wr_lo && wb_req_i.adr == cfs_pkg::OFS_ENABLES) begin
            // bit 4 has no enable and is forced low
            state_d.enable = wb_req_i.dat[7:0] & cfs_pkg::FLAG_MASK;
        end
        if (wr_lo && wb_req_i.adr == cfs_pkg::OFS_FIFO_CTRL) begin
            state_d.area_start = wb_req_i.dat[4:0];
        end
        // upper lanes hold only read-only bits and are ignored
    end

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state_q.ack <= 1'b0;
            state_q.rdata <= 32'h0000_0000;
            state_q.enable <= cfs_pkg::ENABLE_RESET;
            state_q.area_start <= cfs_pkg::AREA_START_RESET;
            state_q.err <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_rsp_o.ack = state_q.ack;
    assign wb_rsp_o.dat = state_q.rdata;
    assign interrupt_source_code_o = code;
    assign irq_o = |pending;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_wptr_in_area:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        fifo_write_pointer <= cfs_pkg::PTR_LAST)
    else $error("write pointer beyond last buffer");

    a_rptr_in_area:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $stable(state_q.area_start) && $past(fifo_read_done_i) == 1'b0
        |-> fifo_next_read_pointer >= {1'b0, state_q.area_start}
            || $past(fifo_next_read_pointer) < {1'b0, state_q.area_start})
    else $error("read pointer left the fifo area");

    a_upper_zero:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wb_rsp_o.ack |-> wb_rsp_o.dat[31:16] == 16'h0000
                         && (wb_rsp_o.dat[15:14] == 2'b00))
    else $error("unimplemented bits read non-zero");

    a_busoff_track:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        err_state_i.tx_bus_off |=> flag_word[cfs_pkg::TX_BUS_OFF_BIT])
    else $error("bus-off state not shown");

    a_tx_passive:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> flag_word[cfs_pkg::TX_PASSIVE_BIT]
        == $past(err_state_i.tx_passive))
    else $error("transmitter passive state not shown");

    a_rx_passive:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> flag_word[cfs_pkg::RX_PASSIVE_BIT]
        == $past(err_state_i.rx_passive))
    else $error("receiver passive state not shown");

    a_tx_warn:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> flag_word[cfs_pkg::TX_WARN_BIT]
        == $past(err_state_i.tx_warn))
    else $error("transmitter warning state not shown");

    a_rx_warn:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !$past(reset_i) |-> flag_word[cfs_pkg::RX_WARN_BIT]
        == $past(err_state_i.rx_warn))
    else $error("receiver warning state not shown");

    a_warn_combined:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (err_state_i.tx_warn || err_state_i.rx_warn)
        |=> flag_word[cfs_pkg::ANY_WARN_BIT])
    else $error("combined warning not shown");

    a_invalid_latch:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        events_i.invalid_msg |=> flags[cfs_pkg::INVALID_BIT] ##1
        (flags[cfs_pkg::INVALID_BIT]
         || $past(flag_clear[cfs_pkg::INVALID_BIT])))
    else $error("invalid message flag not latched");

    a_error_latch:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        err_rise |=> flags[cfs_pkg::ERROR_BIT])
    else $error("error flag not set on new error state");

    a_flag_sticky:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        ((flags & ~flag_clear) != 8'h00) |=>
        (($past(flags) & ~$past(flag_clear) & ~flags) == 8'h00))
    else $error("flag dropped without a clear");

    a_flag_clear:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        flag_clear[cfs_pkg::INVALID_BIT] && !flag_set[cfs_pkg::INVALID_BIT]
        |=> !flags[cfs_pkg::INVALID_BIT])
    else $error("flag not cleared by a zero write");

    a_reset_zero:
    assert property (@(posedge ref_clk_i)
        $past(reset_i) && !reset_i |-> flags == 8'h00
        && state_q.enable == 8'h00 && fifo_write_pointer == 6'h00)
    else $error("state not zero after reset");

    a_interrupt_source_code_none:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        pending == 8'h00 |-> interrupt_source_code_o == 7'h40)
    else $error("idle code wrong");

    a_irq_gate:
    assert property (@(posedge ref_clk_i) disable iff (reset_i)
        irq_o == ((flags & state_q.enable) != 8'h00))
    else $error("interrupt output not gated by enables");

endmodule // cfs_top

// ### test/cfs_engine_model.sv
// cfs_engine_model: protocol engine stand-in feeding error state and pulses
`timescale 1ns/10ps
module cfs_engine_model (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input cfs_pkg::cfs_err_state_type err_i,
    input wire logic [7:0] fire_i,
    output cfs_pkg::cfs_err_state_type err_o,
    output logic [7:0] pulse_o
);
    logic [7:0] fire_q; // last command, kept for edge detection
    // --------------------------------------------------------------
    // a rising command gives one single-cycle pulse, as the engine
    // would; a held command must not retrigger the sticky flags
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        fire_q <= reset_i ? 8'h00 : fire_i;
        pulse_o <= reset_i ? 8'h00 : fire_i & ~fire_q;
        err_o <= reset_i ? '0 : err_i;
    end
endmodule // cfs_engine_model

// ### test/test_can_fifo_status_and_interrupts.sv
// test_can_fifo_status_and_interrupts: self-checking bench of cfs_top
`timescale 1ns/10ps
module test_can_fifo_status_and_interrupts;
    // --------------------------------------------------------------
    // clock, reset and stimulus
    // --------------------------------------------------------------
    logic ref_clk_i = 1'b0; // 25 MHz
    logic reset_i = 1'b1;
    cfs_pkg::cfs_wb_req_type wb_req = '0;
    cfs_pkg::cfs_wb_rsp_type wb_rsp;
    cfs_pkg::cfs_err_state_type err_cmd = '0;
    cfs_pkg::cfs_err_state_type err_s;
    logic [7:0] fire = 8'h00; // [5:0] events, [6] store, [7] read done
    logic [7:0] pul;
    logic [6:0] code;
    logic irq;
    int fail_count = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic [31:0] ex;
    always #20 ref_clk_i = ~ref_clk_i;
    cfs_engine_model u_eng (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .err_i(err_cmd), .fire_i(fire), .err_o(err_s), .pulse_o(pul));
    cfs_top u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .wb_req_i(wb_req), .wb_rsp_o(wb_rsp), .err_state_i(err_s),
        .events_i(pul[5:0]),
        .fifo_store_i(pul[6]), .fifo_read_done_i(pul[7]),
        .interrupt_source_code_o(code), .irq_o(irq));
    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // one classic cycle; the request stands until ack is seen
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        wb_req <= {1'b1, 1'b1, we, a, 4'hF, d};
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        rd = wb_rsp.dat;
        if (n >= 20) begin
            fail_count++;
            $display("BAD ack expected 1 seen %b", wb_rsp.ack);
        end
        wb_req <= '0;
        @(posedge ref_clk_i); // idle cycle between accesses
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // command one pulse and let it reach the flags
    task pulse(input logic [7:0] m);
        fire <= m;
        tick(1);
        fire <= 8'h00;
        tick(3);
    endtask
    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task t_reset;
        rdc(8'h00, 32'h0, "status");
        rdc(8'h04, 32'h0, "flags");
        rdc(8'h08, 32'h0, "enables");
        chk("code", 32'h40, {25'h0, code});
        chk("irq", 32'h0, {31'h0, irq});
    endtask
    // each error state alone, the error flag cleared before it rises
    task t_err;
        logic [4:0] e;
        for (int i = 0; i < 5; i++) begin
            e = 5'h01 << i;
            wb(1'b1, 8'h04, 32'h0);
            err_cmd <= e;
            tick(3);
            ex = {18'h0, e, |e[1:0], 8'h20};
            rdc(8'h04, ex, "err");
            chk("tx warn", {31'h0, e[1]}, {31'h0, rd[10]});
            chk("rx warn", {31'h0, e[0]}, {31'h0, rd[9]});
            chk("any warn", {31'h0, |e[1:0]}, {31'h0, rd[8]});
            chk("err flag", 32'h1, {31'h0, rd[5]});
            err_cmd <= '0;
            tick(3);
        end
        rdc(8'h04, 32'h20, "err sticky");
        wb(1'b1, 8'h04, 32'h0);
        rdc(8'h04, 32'h0, "err clear");
    endtask
    task t_events;
        int pos[6] = '{0, 1, 2, 3, 6, 7};
        ex = 32'h0;
        for (int i = 0; i < 6; i++) begin
            pulse(8'h01 << i);
            ex[pos[i]] = 1'b1;
            rdc(8'h04, ex, "event");
            chk("new", 32'h1, rd >> pos[i]);
        end
        wb(1'b1, 8'h04, 32'hFFFF);
        rdc(8'h04, 32'hCF, "write one");
        wb(1'b1, 8'h04, 32'hFF7F);
        rdc(8'h04, 32'h4F, "write zero");
        wb(1'b1, 8'h04, 32'h0);
    endtask
    // sources added one by one, each outranking the one before
    task t_irq;
        wb(1'b1, 8'h08, 32'hFFFF);
        rdc(8'h08, 32'hEF, "enables");
        pulse(8'h10); // wake-up
        chk("code wake", 32'h42, {25'h0, code});
        pulse(8'h08); // fifo almost full
        chk("code af", 32'h44, {25'h0, code});
        chk("irq on", 32'h1, {31'h0, irq});
        pulse(8'h04); // receive overflow
        rdc(8'h0C, 32'h43, "code ovf");
        err_cmd <= 5'h01; // receiver warning
        tick(3);
        rdc(8'h0C, 32'h41, "code err");
        err_cmd <= '0;
        wb(1'b1, 8'h08, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        chk("code off", 32'h40, {25'h0, code});
        wb(1'b1, 8'h04, 32'h0);
    endtask
    task t_ptr;
        repeat (3) pulse(8'h40);
        pulse(8'h80);
        wb(1'b1, 8'h00, 32'hFFFF); // read-only, must be ignored
        rdc(8'h00, 32'h0301, "pointers");
        wb(1'b1, 8'h10, 32'h1E);
        tick(2);
        rdc(8'h10, 32'h1E, "area start");
        rdc(8'h00, 32'h1E1E, "area pull");
        pulse(8'h40);
        rdc(8'h00, 32'h1F1E, "last");
        pulse(8'h40);
        rdc(8'h00, 32'h1E1E, "wrap");
        rdc(8'h20, 32'h0, "unmapped");
    endtask
    // --------------------------------------------------------------
    // verdict, main sequence and watchdog
    // --------------------------------------------------------------
    task complete_run;
        $display("fail_count %0d tests_run %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        tick(20);
        reset_i <= 1'b0;
        tick(1);
        t_reset;
        t_err;
        t_events;
        t_irq;
        t_ptr;
        complete_run;
    end
    // the whole run needs well under a thousand cycles
    initial begin
        tick(5000);
        fail_count++;
        complete_run;
    end
endmodule // test_can_fifo_status_and_interrupts
